// ==== rtl/pes_regs.sv ====
`include "pes_map.svh"
// Notes on behaviour
// - Halt in packet flags MAC, latches 17.6.
// - Two idles in packet latch 17.5.
// - Halt and premature flags undefined in 10Base-T.
// - 17.4 shows negotiation done and enabled.
// - 17.3 mirrors 100Base-TX signal presence.
// - 17.2 mirrors basic jabber detect.
// - 17.1 mirrors basic remote fault.
// - 17.0 mirrors basic link status.
// - Receive jabber latches 18.15, no other action.
// - Reversed pair polarity latches 18.14.
// - Polarity reversal disturbs nothing else.
// - 18.5 disables transmit jabber checking.
// - 18.3 inhibits automatic polarity correction.
// - Polarity correction also applies to 100Base-TX.
// - 18.2 disables SQE test generation.
// - 18.1 forces 10Base-T link pass.
// - 18.0 drops idle need for link.
// - Duplex or repeater suppresses SQE silently.
module pes_regs
  import pes_pkg::*;
#(
  parameter int unsigned JAB_CYCLES = `PES_JAB_CYC
)
(
  // Clock and reset.
  input  wire logic  clk,
  input  wire logic  resetn,
  // Management register access.
  input  wire pes_mreq_t  mreq,
  output logic [15:0]     rd_data,
  output logic            rd_valid,
  // Receive and status inputs.
  input  wire pes_rx100_t rx,
  input  wire pes_rx10_t  rx10,
  input  wire pes_bsr_t   bsr,
  input  wire logic       full_duplex,
  input  wire logic       repeater,
  // Controls toward the port logic.
  output logic            halt_to_mac,
  output logic            jabber_chk_en,
  output logic            pol_swap_en,
  output logic            sqe_en,
  output logic            link10_pass
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  localparam logic [`PES_JAB_W-1:0] JAB_LAST = `PES_JAB_W'(JAB_CYCLES - 1);

  // Own state of this module in one record; the flags and the link state sit in their instances.
  typedef struct packed {
    pes_ops_ctrl_t           ctrl;        // Writable controls.
    logic                    prev_idle;   // Last symbol in packet was idle.
    logic [`PES_JAB_W-1:0]   jab_cnt;     // Receive activity length.
    logic [15:0]             rd_data;     // Registered read answer.
    logic                    rd_valid;    // Read answer strobe.
    logic                    halt_mac;    // Halt notice to MAC side.
    logic                    jab_chk_en;  // Transmit jabber check enable.
    logic                    pol_swap_en; // Receive pair swap enable.
    logic                    sqe_en;      // SQE test enable.
  } pes_top_st_t;

  pes_top_st_t st_r;
  pes_top_st_t st_nxt;

  logic rd17;    // Read of extended status.
  logic rd18;    // Read of operations register.
  logic wr18;    // Write of operations register.
  logic halt_ev; // Halt symbol inside a packet.
  logic prem_ev; // Second idle in a row inside a packet.
  logic jab_ev;  // Receive activity reached jabber length.
  logic halt_q;  // Latched flags.
  logic prem_q;
  logic rjab_q;
  logic pol_q;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode and events.
  assign rd17 = mreq.rd && (mreq.addr == `PES_ADDR_EXT_STAT);
  assign rd18 = mreq.rd && (mreq.addr == `PES_ADDR_OPS10);
  assign wr18 = mreq.wr && (mreq.addr == `PES_ADDR_OPS10);

  // Symbol checks only run in 100Base mode; in 10Base-T the flags just
  // keep whatever they held, which software must ignore there.
  assign halt_ev = rx.mode_100 && rx.pkt_active && rx.sym_strobe && rx.sym_is_halt;
  assign prem_ev = rx.mode_100 && rx.pkt_active && rx.sym_strobe && rx.sym_is_idle
                   && st_r.prev_idle;

  // The counter saturates, so the event stays up while jabber lasts.
  assign jab_ev = rx10.rx_active && !rx.mode_100 && (st_r.jab_cnt == JAB_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Latched-high status flags, cleared by a read of their register.
  pes_lh_flag u_halt
  (
    .clk    (clk),
    .resetn (resetn),
    .set    (halt_ev),
    .clr    (rd17),
    .q      (halt_q)
  );

  pes_lh_flag u_prem
  (
    .clk    (clk),
    .resetn (resetn),
    .set    (prem_ev),
    .clr    (rd17),
    .q      (prem_q)
  );

  // Receive jabber is reported only; nothing else reacts to it.
  pes_lh_flag u_rjab
  (
    .clk    (clk),
    .resetn (resetn),
    .set    (jab_ev),
    .clr    (rd18),
    .q      (rjab_q)
  );

  // Reads as zero again once polarity is seen correct after a read.
  pes_lh_flag u_pol
  (
    .clk    (clk),
    .resetn (resetn),
    .set    (rx10.pol_rev),
    .clr    (rd18),
    .q      (pol_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 10Base-T link integrity.
  pes_link10 u_link
  (
    .clk       (clk),
    .resetn    (resetn),
    .data_ok   (rx10.data_ok),
    .idle_ok   (rx10.idle_ok),
    .link_fail (rx10.link_fail),
    .ll_inh    (st_r.ctrl.ll_inh),
    .sq_inh    (st_r.ctrl.sq_inh),
    .link_pass (link10_pass)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state of this module's own state record.
  always_comb
  begin
    logic [15:0] r17;
    logic [15:0] r18;
    r17    = `PES_ZERO16;
    r18    = `PES_ZERO16;
    st_nxt = st_r;

    // Idle history only counts inside a 100Base packet.
    if (!(rx.mode_100 && rx.pkt_active))
      st_nxt.prev_idle = 1'b0;
    else if (rx.sym_strobe)
      st_nxt.prev_idle = rx.sym_is_idle;

    // Receive activity length for the jabber check.
    if (!rx10.rx_active || rx.mode_100)
      st_nxt.jab_cnt = '0;
    else if (st_r.jab_cnt != JAB_LAST)
      st_nxt.jab_cnt = st_r.jab_cnt + `PES_JAB_W'(1);

    // Reserved bits of a write are dropped; the manager writes their
    // defaults anyway, so storing them would buy nothing.
    if (wr18)
    begin
      st_nxt.ctrl.jab_inh  = mreq.wdata[`PES_B18_JABINH];
      st_nxt.ctrl.apol_inh = mreq.wdata[`PES_B18_APOL];
      st_nxt.ctrl.sqe_inh  = mreq.wdata[`PES_B18_SQE];
      st_nxt.ctrl.ll_inh   = mreq.wdata[`PES_B18_LLINH];
      st_nxt.ctrl.sq_inh   = mreq.wdata[`PES_B18_SQINH];
    end

    // Extended status, low half; upper bits read zero here.
    r17[`PES_B17_HALT]   = halt_q;
    r17[`PES_B17_PREM]   = prem_q;
    r17[`PES_B17_ANDONE] = bsr.an_enable && bsr.an_done;
    r17[`PES_B17_SIGDET] = rx.mode_100 && bsr.sig_detect;
    r17[`PES_B17_JAB]    = bsr.jabber;
    r17[`PES_B17_RFLT]   = bsr.remote_fault;
    r17[`PES_B17_LINK]   = bsr.link_up;

    // Operations register; reserved bits read their defaults.
    r18[`PES_B18_RJAB]   = rjab_q;
    r18[`PES_B18_POL]    = pol_q;
    r18[`PES_B18_JABINH] = st_r.ctrl.jab_inh;
    r18[`PES_B18_RSV1]   = `PES_RSV1_VAL;
    r18[`PES_B18_APOL]   = st_r.ctrl.apol_inh;
    r18[`PES_B18_SQE]    = st_r.ctrl.sqe_inh;
    r18[`PES_B18_LLINH]  = st_r.ctrl.ll_inh;
    r18[`PES_B18_SQINH]  = st_r.ctrl.sq_inh;

    // Read answer captures the flags before their clear lands.
    st_nxt.rd_valid = mreq.rd;
    if (rd17)
      st_nxt.rd_data = r17;
    else if (rd18)
      st_nxt.rd_data = r18;
    else
      st_nxt.rd_data = `PES_ZERO16;

    // Port controls, each from a flop.
    st_nxt.halt_mac    = halt_ev;
    st_nxt.jab_chk_en  = !st_r.ctrl.jab_inh;
    // Swap is the only port control driven by reversal and is used in both modes.
    st_nxt.pol_swap_en = rx10.pol_rev && !st_r.ctrl.apol_inh;
    // Automatic suppression leaves the control bit untouched.
    st_nxt.sqe_en      = !st_r.ctrl.sqe_inh && !full_duplex && !repeater;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset to defaults.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_r            <= '0;
      st_r.ctrl       <= `PES_OPS_CTRL_RST;
      st_r.jab_chk_en <= `PES_JABCHK_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign rd_data       = st_r.rd_data;
  assign rd_valid      = st_r.rd_valid;
  assign halt_to_mac   = st_r.halt_mac;
  assign jabber_chk_en = st_r.jab_chk_en;
  assign pol_swap_en   = st_r.pol_swap_en;
  assign sqe_en        = st_r.sqe_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_halt_mac;
    halt_ev |=> (halt_to_mac && halt_q);
  endproperty
  a_halt_mac: assert property (p_halt_mac) else $error("halt not reported");

  sequence s_idle_pkt;
    rx.mode_100 && rx.pkt_active && rx.sym_strobe && rx.sym_is_idle;
  endsequence
  property p_prem;
    s_idle_pkt ##1 s_idle_pkt |=> prem_q;
  endproperty
  a_prem: assert property (p_prem) else $error("premature end missed");

  property p_ten_quiet;
    (!rx.mode_100 && !halt_q && !prem_q) |=> (!halt_q && !prem_q);
  endproperty
  a_ten_quiet: assert property (p_ten_quiet) else $error("symbol flag set in 10Base-T");

  property p_an_done;
    rd17 |=> (rd_valid && rd_data[`PES_B17_ANDONE] == $past(bsr.an_enable && bsr.an_done));
  endproperty
  a_an_done: assert property (p_an_done) else $error("negotiation done bit wrong");

  property p_mirror;
    rd17 |=> (rd_data[`PES_B17_LINK] == $past(bsr.link_up) && rd_data[`PES_B17_RFLT] == $past(bsr.remote_fault)
              && rd_data[`PES_B17_JAB] == $past(bsr.jabber));
  endproperty
  a_mirror: assert property (p_mirror) else $error("basic status mirror wrong");

  property p_rd_clear;
    (halt_q && rd17 && !halt_ev) |=> (rd_data[`PES_B17_HALT] && !halt_q);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not return then clear");

  property p_jab;
    jab_ev |=> rjab_q;
  endproperty
  a_jab: assert property (p_jab) else $error("receive jabber not latched");

  property p_jabchk;
    wr18 |=> ##1 (jabber_chk_en == !$past(mreq.wdata[`PES_B18_JABINH], 2));
  endproperty
  a_jabchk: assert property (p_jabchk) else $error("jabber check enable wrong");

  property p_pol;
    (rx10.pol_rev && !st_r.ctrl.apol_inh) |=> pol_swap_en;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not corrected");

  property p_sqe;
    (full_duplex || repeater) |=> !sqe_en;
  endproperty
  a_sqe: assert property (p_sqe) else $error("SQE not suppressed");

  property p_rst;
    disable iff (1'b0)
    !resetn |=> (st_r.ctrl == `PES_OPS_CTRL_RST && !halt_q && !rjab_q && !pol_q);
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
endmodule : pes_regs

// ==== rtl/pes_map.svh ====
`ifndef PES_MAP_SVH
`define PES_MAP_SVH
// Management register addresses.
`define PES_ADDR_EXT_STAT 5'h11
`define PES_ADDR_OPS10    5'h12
// Extended status (low half) bit positions.
`define PES_B17_HALT   6
`define PES_B17_PREM   5
`define PES_B17_ANDONE 4
`define PES_B17_SIGDET 3
`define PES_B17_JAB    2
`define PES_B17_RFLT   1
`define PES_B17_LINK   0
// 10Base-T operations bit positions.
`define PES_B18_RJAB   15
`define PES_B18_POL    14
`define PES_B18_JABINH 5
`define PES_B18_RSV1   4
`define PES_B18_APOL   3
`define PES_B18_SQE    2
`define PES_B18_LLINH  1
`define PES_B18_SQINH  0
// Reset and fixed read values.
`define PES_OPS_CTRL_RST 5'h00
`define PES_RSV1_VAL     1'b1
`define PES_JABCHK_RST   1'b1
`define PES_ZERO16       16'h0000
// Receive jabber timing.
`define PES_CLK_MHZ    40
`define PES_JAB_MIN_US 20000
`define PES_JAB_CYC    (`PES_JAB_MIN_US * `PES_CLK_MHZ)
`define PES_JAB_W      20
`endif

// ==== rtl/pes_pkg.sv ====
package pes_pkg;
  // One management access request, valid for one cycle.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pes_mreq_t;
  // 100Base receive symbol events.
  typedef struct packed {
    logic mode_100;
    logic pkt_active;
    logic sym_strobe;
    logic sym_is_halt;
    logic sym_is_idle;
  } pes_rx100_t;
  // Live status from negotiation and basic status logic.
  typedef struct packed {
    logic an_enable;
    logic an_done;
    logic sig_detect;
    logic jabber;
    logic remote_fault;
    logic link_up;
  } pes_bsr_t;
  // 10Base-T receive conditions.
  typedef struct packed {
    logic rx_active;
    logic data_ok;
    logic idle_ok;
    logic link_fail;
    logic pol_rev;
  } pes_rx10_t;
  // Writable controls of the operations register.
  typedef struct packed {
    logic jab_inh;
    logic apol_inh;
    logic sqe_inh;
    logic ll_inh;
    logic sq_inh;
  } pes_ops_ctrl_t;
  // Link integrity states.
  typedef enum logic [1:0] {PES_L_FAIL, PES_L_DATA, PES_L_PASS} pes_link_st_t;
endpackage : pes_pkg

// ==== rtl/pes_lh_flag.sv ====
`include "pes_map.svh"
module pes_lh_flag
  import pes_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Event and read strobe.
  input  wire logic set,
  input  wire logic clr,
  // Held flag.
  output logic      q
);
  typedef struct packed {
    logic q;
  } pes_flag_st_t;
  pes_flag_st_t st_r;
  pes_flag_st_t st_nxt;

  // A live event beats the read clear so nothing is lost.
  always_comb
  begin
    st_nxt   = st_r;
    st_nxt.q = set | (st_r.q & ~clr);
  end

  // Flags come out of reset cleared.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.q;

  property p_set_hold;
    @(posedge clk) disable iff (!resetn)
    (set || (q && !clr)) |=> q;
  endproperty
  a_set_hold: assert property (p_set_hold) else $error("flag lost its event");

  property p_rd_clear;
    @(posedge clk) disable iff (!resetn)
    (clr && !set) |=> !q;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flag not cleared by read");
endmodule : pes_lh_flag

// ==== rtl/pes_link10.sv ====
`include "pes_map.svh"
module pes_link10
  import pes_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Receive qualifiers.
  input  wire logic data_ok,
  input  wire logic idle_ok,
  input  wire logic link_fail,
  // Controls.
  input  wire logic ll_inh,
  input  wire logic sq_inh,
  // Link result.
  output logic      link_pass
);
  typedef struct packed {
    pes_link_st_t state;
    logic         pass;
  } pes_lnk_st_t;
  pes_lnk_st_t st_r;
  pes_lnk_st_t st_nxt;

  // Link integrity walk; the inhibit overrides every failure.
  always_comb
  begin
    st_nxt = st_r;
    case (st_r.state)
      PES_L_FAIL:
      begin
        if (data_ok)
          st_nxt.state = sq_inh ? PES_L_PASS : PES_L_DATA;
      end
      PES_L_DATA:
      begin
        if (link_fail)
          st_nxt.state = PES_L_FAIL;
        else if (idle_ok)
          st_nxt.state = PES_L_PASS;
      end
      PES_L_PASS:
      begin
        if (link_fail)
          st_nxt.state = PES_L_FAIL;
      end
      default:
      begin
        st_nxt.state = PES_L_FAIL;
      end
    endcase
    if (ll_inh)
      st_nxt.state = PES_L_PASS;
    st_nxt.pass = (st_nxt.state == PES_L_PASS);
  end

  // Link starts failed after reset.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_r.state <= PES_L_FAIL;
      st_r.pass  <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign link_pass = st_r.pass;

  property p_ll_force;
    @(posedge clk) disable iff (!resetn)
    ll_inh |=> link_pass;
  endproperty
  a_ll_force: assert property (p_ll_force) else $error("link not forced to pass");

  property p_sq_data;
    @(posedge clk) disable iff (!resetn)
    (st_r.state == PES_L_FAIL && data_ok && !idle_ok && !sq_inh && !ll_inh) |=> !link_pass;
  endproperty
  a_sq_data: assert property (p_sq_data) else $error("link passed without idle");
endmodule : pes_link10

// ==== tb/pes_sta_model.sv ====
`include "pes_map.svh"
module pes_sta_model
  import pes_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Request toward the register block.
  output pes_mreq_t        mreq,
  // Read answer.
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle until the first request.
  initial mreq = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Hold one request for its taking edge, then release it.
  // Address and data are inverted on release, rd and wr cleared, so a stale value never looks current.
  task automatic issue(input logic rd, input logic [4:0] addr, input logic [15:0] wdata);
    begin
      @(posedge clk);
      mreq <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
      @(posedge clk);
      mreq <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    end
  endtask : issue

  // Write one word; reserved fields of the operations register carry their defaults.
  task automatic reg_write(input logic [4:0] addr, input logic [15:0] data);
    logic [15:0] w;
    begin
      w = data;
      if (addr == `PES_ADDR_OPS10)
      begin
        w[13:6]           = 8'h00;
        w[`PES_B18_RSV1]  = `PES_RSV1_VAL;
      end
      issue(1'b0, addr, w);
    end
  endtask : reg_write

  // Read one word; the answer is awaited for a few cycles only.
  task automatic reg_read(input logic [4:0] addr, output logic [15:0] data, output logic ok);
    begin
      issue(1'b1, addr, 16'h0000);
      ok   = 1'b0;
      data = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++)
      begin
        #1;
        if (rd_valid === 1'b1)
        begin
          ok   = 1'b1;
          data = rd_data;
        end
        else
          @(posedge clk);
      end
    end
  endtask : reg_read
endmodule : pes_sta_model

// ==== tb/pes_regs_tb.sv ====
`include "pes_map.svh"
module pes_regs_tb
  import pes_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  // A short jabber span keeps the run brief.
  localparam int JAB = 8;

  logic        clk = 1'b0;
  logic        resetn;
  pes_mreq_t   mreq;
  logic [15:0] rd_data;
  logic        rd_valid;
  pes_rx100_t  rx;
  pes_rx10_t   rx10;
  pes_bsr_t    bsr;
  logic        full_duplex;
  logic        repeater;
  logic        halt_to_mac;
  logic        jabber_chk_en;
  logic        pol_swap_en;
  logic        sqe_en;
  logic        link10_pass;
  int          fail_count  = 0;
  int          comparisons = 0;

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  pes_regs #(.JAB_CYCLES(JAB)) pes_regs_i (.clk(clk), .resetn(resetn), .mreq(mreq), .rd_data(rd_data),
    .rd_valid(rd_valid), .rx(rx), .rx10(rx10), .bsr(bsr), .full_duplex(full_duplex), .repeater(repeater),
    .halt_to_mac(halt_to_mac), .jabber_chk_en(jabber_chk_en), .pol_swap_en(pol_swap_en), .sqe_en(sqe_en),
    .link10_pass(link10_pass));

  pes_sta_model pes_sta_model_i (.clk(clk), .mreq(mreq), .rd_data(rd_data), .rd_valid(rd_valid));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      comparisons++;
      if (got !== exp)
      begin
        fail_count++;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : check

  // Read a register and judge both the answer strobe and the word.
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    begin
      pes_sta_model_i.reg_read(a, d, ok);
      check("rd_valid", 16'h0001, {15'h0000, ok});
      check($sformatf("reg %h", a), exp, d);
    end
  endtask : rd_chk

  // Control outputs as one nibble: jabber, polarity, sqe, link.
  task automatic outs(input logic [3:0] exp);
    begin
      check("controls", {12'h000, exp}, {12'h000, jabber_chk_en, pol_swap_en, sqe_en, link10_pass});
    end
  endtask : outs

  // Let n edges pass, then step off the edge so outputs are settled.
  task automatic cyc(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask : cyc

  // One strobed 100Base symbol.
  task automatic sym(input logic h, input logic i);
    begin
      @(posedge clk);
      rx.sym_strobe  <= 1'b1;
      rx.sym_is_halt <= h;
      rx.sym_is_idle <= i;
      @(posedge clk);
      rx.sym_strobe  <= 1'b0;
    end
  endtask : sym

  // One-cycle pulse on a 10Base-T receive condition, then settle.
  task automatic pulse(input int b);
    begin
      @(posedge clk);
      rx10[b] <= 1'b1;
      @(posedge clk);
      rx10[b] <= 1'b0;
      cyc(3);
    end
  endtask : pulse

  // Set live status and mode, then read the extended status word.
  task automatic mir(input logic [5:0] b, input logic m, input logic [15:0] exp);
    begin
      @(posedge clk);
      bsr         <= b;
      rx.mode_100 <= m;
      cyc(2);
      rd_chk(`PES_ADDR_EXT_STAT, exp);
    end
  endtask : mir

  ////////////////////////////////////////////////////////////////////////////
  // Defaults after reset, and an unmapped address reads zero.
  task automatic t_reset();
    begin
      outs(4'b1010);
      rd_chk(`PES_ADDR_OPS10, 16'h0010);
      rd_chk(`PES_ADDR_EXT_STAT, 16'h0000);
      rd_chk(5'h00, 16'h0000);
    end
  endtask : t_reset

  // Halt symbol: pulse toward the MAC, flag held until read.
  task automatic t_halt();
    begin
      @(posedge clk);
      rx.mode_100   <= 1'b1;
      rx.pkt_active <= 1'b1;
      sym(1'b1, 1'b0);
      #1;
      check("halt_to_mac", 16'h0001, {15'h0000, halt_to_mac});
      cyc(1);
      check("halt_to_mac", 16'h0000, {15'h0000, halt_to_mac});
      rd_chk(`PES_ADDR_EXT_STAT, 16'h0040);
      rd_chk(`PES_ADDR_EXT_STAT, 16'h0000);
    end
  endtask : t_halt

  // An idle followed by data must not count; two in a row must.
  task automatic t_prem();
    begin
      sym(1'b0, 1'b1);
      sym(1'b0, 1'b0);
      sym(1'b0, 1'b0);
      rd_chk(`PES_ADDR_EXT_STAT, 16'h0000);
      sym(1'b0, 1'b1);
      sym(1'b0, 1'b1);
      rd_chk(`PES_ADDR_EXT_STAT, 16'h0020);
      rd_chk(`PES_ADDR_EXT_STAT, 16'h0000);
      @(posedge clk);
      rx.pkt_active <= 1'b0;
    end
  endtask : t_prem

  // Mirrored status bits follow their sources.
  task automatic t_mirror();
    begin
      mir(6'b110000, 1'b1, 16'h0010);
      mir(6'b010000, 1'b1, 16'h0000);
      mir(6'b001000, 1'b1, 16'h0008);
      mir(6'b001000, 1'b0, 16'h0000);
      for (int i = 0; i < 3; i++)
        mir(6'b000001 << i, 1'b0, 16'h0001 << i);
      mir(6'b000000, 1'b1, 16'h0000);
    end
  endtask : t_mirror

  // Control bits, the silent sqe suppression, and the polarity flag.
  task automatic t_ctrl();
    begin
      @(posedge clk);
      rx10.pol_rev <= 1'b1;
      pes_sta_model_i.reg_write(`PES_ADDR_OPS10, 16'h0010);
      cyc(3);
      outs(4'b1110);
      rd_chk(`PES_ADDR_OPS10, 16'h4010);
      pes_sta_model_i.reg_write(`PES_ADDR_OPS10, 16'h002c);
      cyc(3);
      outs(4'b0000);
      rd_chk(`PES_ADDR_OPS10, 16'h403c);
      pes_sta_model_i.reg_write(`PES_ADDR_OPS10, 16'h0010);
      full_duplex <= 1'b1;
      cyc(3);
      outs(4'b1100);
      rd_chk(`PES_ADDR_OPS10, 16'h4010);
      @(posedge clk);
      full_duplex <= 1'b0;
      repeater    <= 1'b1;
      cyc(3);
      outs(4'b1100);
      @(posedge clk);
      repeater     <= 1'b0;
      rx10.pol_rev <= 1'b0;
      cyc(2);
      rd_chk(`PES_ADDR_OPS10, 16'h4010);
      rd_chk(`PES_ADDR_OPS10, 16'h0010);
    end
  endtask : t_ctrl

  // Receive jabber: short activity is ignored, long activity latches.
  task automatic t_jab();
    begin
      @(posedge clk);
      rx.mode_100    <= 1'b0;
      rx10.rx_active <= 1'b1;
      repeat (JAB - 4) @(posedge clk);
      rx10.rx_active <= 1'b0;
      cyc(2);
      rd_chk(`PES_ADDR_OPS10, 16'h0010);
      @(posedge clk);
      rx10.rx_active <= 1'b1;
      repeat (JAB + 4) @(posedge clk);
      rx10.rx_active <= 1'b0;
      cyc(2);
      outs(4'b1010);
      rd_chk(`PES_ADDR_OPS10, 16'h8010);
      rd_chk(`PES_ADDR_OPS10, 16'h0010);
    end
  endtask : t_jab

  // Link integrity with and without squelch, forced pass, reversed pair.
  task automatic t_link();
    begin
      @(posedge clk);
      rx10.pol_rev <= 1'b1;
      pulse(3);
      outs(4'b1110);
      pulse(2);
      outs(4'b1111);
      pulse(1);
      outs(4'b1110);
      pes_sta_model_i.reg_write(`PES_ADDR_OPS10, 16'h0011);
      pulse(3);
      outs(4'b1111);
      @(posedge clk);
      rx10.link_fail <= 1'b1;
      cyc(3);
      outs(4'b1110);
      pes_sta_model_i.reg_write(`PES_ADDR_OPS10, 16'h0012);
      cyc(3);
      outs(4'b1111);
      pes_sta_model_i.reg_write(`PES_ADDR_OPS10, 16'h0010);
      cyc(3);
      outs(4'b1110);
      @(posedge clk);
      rx10.link_fail <= 1'b0;
      rx10.pol_rev   <= 1'b0;
    end
  endtask : t_link

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic conclude();
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : conclude

  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    resetn      = 1'b0;
    rx          = '0;
    rx10        = '0;
    bsr         = '0;
    full_duplex = 1'b0;
    repeater    = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    cyc(2);
    t_reset();
    t_halt();
    t_prem();
    t_mirror();
    t_ctrl();
    t_jab();
    t_link();
    conclude();
  end
endmodule : pes_regs_tb
